// file: include/stop_seq_pkg.sv
// Constants for the drive stop and torque-off sequencer.
// Operation
// RULE_01: hardware permit removal cuts power stage at once
// RULE_02: stop input gives controlled ramp, disable, brake
// RULE_03: brake on velocity below threshold or timeout
// RULE_04: brake-immediate setting brakes right after fault/hardware
// RULE_05: host sets disable mode to two first
// RULE_06: software disable gives category one stop
// RULE_07: immediate-disable fault cuts power stage at once
// RULE_08: dynamic-braking fault stops by dynamic braking
// RULE_09: controlled-stop fault ramps down before disable
// RULE_10: one string permit input and state output
// RULE_11: local variant ignores string torque-off permit
// RULE_12: local torque-off state joins string state output
// RULE_13: string permit fall cuts energy within 10 ms
// RULE_14: local permit fall cuts energy within 10 ms
// RULE_15: state outputs are informational, not safety
// RULE_16: dynamic braking shorts q axis, d zero, limited
// RULE_17: torque needs local permit and hardware permit
// RULE_18: local input ignores short spaced test pulses
// RULE_19: stop timeout counted from start, cleared on enable
package stop_seq_pkg;
   localparam int unsigned CLK_HZ = 250_000_000;
   // Register map, byte addresses of 32-bit words.
   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_VTHR = 5'h04;
   localparam logic [4:0] OFS_TOUT = 5'h08;
   localparam logic [4:0] OFS_DBIL = 5'h0C;
   localparam logic [4:0] OFS_STAT = 5'h10;
   localparam logic [4:0] OFS_IRQ  = 5'h14;
   localparam logic [4:0] OFS_MASK = 5'h18;
   // Control register fields.
   localparam int unsigned BIT_RUN   = 0;
   localparam int unsigned BIT_BIMM  = 1;
   localparam int unsigned BIT_LOCAL = 2;
   localparam int unsigned POS_MODE  = 4;
   localparam logic [1:0] MODE_CATS  = 2'h2;
   localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
   localparam logic [15:0] VTHR_RST  = 16'h0010;
   localparam logic [31:0] TOUT_RST  = 32'h000F_4240;
   localparam logic [15:0] DBIL_RST  = 16'h0100;
   // Interrupt event bits.
   localparam int unsigned EV_STOP   = 0;
   localparam int unsigned EV_BRAKE  = 1;
   localparam int unsigned EV_FAULT  = 2;
   localparam int unsigned EV_TORQUE = 3;
   localparam int unsigned EV_W      = 4;
   // Torque-off reaction budget and test pulse figures.
   localparam int unsigned REACT_MS  = 10;
   localparam int unsigned PULSE_US  = 300;
   localparam int unsigned GAP_MS    = 200;
   localparam int unsigned PULSE_CYC = PULSE_US * (CLK_HZ / 1_000_000);
   localparam int unsigned GAP_CYC   = GAP_MS * (CLK_HZ / 1_000);
   localparam int unsigned REACT_CYC = REACT_MS * (CLK_HZ / 1_000);
   typedef enum logic [1:0] {FLT_NONE, FLT_IMM, FLT_DYN, FLT_CTRL} fault_t;
   typedef enum {ST_OFF, ST_RUN, ST_RAMP, ST_DYN, ST_COAST, ST_BRAKED} stop_state_t;
endpackage

// file: hdl/stop_sequencer.sv
// Stop category sequencer with torque-off handling and Avalon-MM registers.
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
module stop_sequencer #(
   parameter int unsigned PULSE_CYC = stop_seq_pkg::PULSE_CYC,
   parameter int unsigned GAP_CYC   = stop_seq_pkg::GAP_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        string_hardware_permit,
   input  wire logic        torque_off_permit_input,
   input  wire logic        local_torque_off_input,
   input  wire logic        stop_input,
   input  wire logic [1:0]  fault_class,
   input  wire logic [15:0] velocity_abs,
   output logic             power_stage_on,
   output logic             ramp_down,
   output logic             dyn_brake,
   output logic [15:0]      dyn_brake_ilimit,
   output logic             brake_apply,
   output logic             torque_off_state_output,
   output logic             irq
);
   // The filter needs at least one cycle of pulse limit and a gap above it.
   if (PULSE_CYC < 1 || GAP_CYC <= PULSE_CYC) begin
      $error("Pulse filter counts cannot be served.");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Local names for the package enumerations, since nothing is imported.
   localparam stop_seq_pkg::stop_state_t ST_OFF    = stop_seq_pkg::ST_OFF;
   localparam stop_seq_pkg::stop_state_t ST_RUN    = stop_seq_pkg::ST_RUN;
   localparam stop_seq_pkg::stop_state_t ST_RAMP   = stop_seq_pkg::ST_RAMP;
   localparam stop_seq_pkg::stop_state_t ST_DYN    = stop_seq_pkg::ST_DYN;
   localparam stop_seq_pkg::stop_state_t ST_COAST  = stop_seq_pkg::ST_COAST;
   localparam stop_seq_pkg::stop_state_t ST_BRAKED = stop_seq_pkg::ST_BRAKED;
   localparam stop_seq_pkg::fault_t      FLT_NONE  = stop_seq_pkg::FLT_NONE;
   localparam stop_seq_pkg::fault_t      FLT_IMM   = stop_seq_pkg::FLT_IMM;
   localparam stop_seq_pkg::fault_t      FLT_DYN   = stop_seq_pkg::FLT_DYN;
   localparam stop_seq_pkg::fault_t      FLT_CTRL  = stop_seq_pkg::FLT_CTRL;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: three stages, change accepted when stages two and three agree.
   logic [2:0] s_hw_r, s_gl_r, s_lo_r, s_st_r;
   logic [2:0] s_hw_nxt, s_gl_nxt, s_lo_nxt, s_st_nxt;
   logic       hw_r, gl_r, lo_raw_r, st_r;
   logic       hw_nxt, gl_nxt, lo_raw_nxt, st_nxt;

   always_comb begin
      s_hw_nxt = {s_hw_r[1:0], string_hardware_permit};
      s_gl_nxt = {s_gl_r[1:0], torque_off_permit_input};
      s_lo_nxt = {s_lo_r[1:0], local_torque_off_input};
      s_st_nxt = {s_st_r[1:0], stop_input};
      // A change counts only once the two later stages agree on it.
      hw_nxt     = (s_hw_r[1] == s_hw_r[2]) ? s_hw_r[2] : hw_r;
      gl_nxt     = (s_gl_r[1] == s_gl_r[2]) ? s_gl_r[2] : gl_r;
      lo_raw_nxt = (s_lo_r[1] == s_lo_r[2]) ? s_lo_r[2] : lo_raw_r;
      st_nxt     = (s_st_r[1] == s_st_r[2]) ? s_st_r[2] : st_r;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         s_hw_r   <= 3'h0;
         s_gl_r   <= 3'h0;
         s_lo_r   <= 3'h0;
         s_st_r   <= 3'h0;
         hw_r     <= 1'b0;
         gl_r     <= 1'b0;
         lo_raw_r <= 1'b0;
         st_r     <= 1'b0;
      end else begin
         s_hw_r   <= s_hw_nxt;
         s_gl_r   <= s_gl_nxt;
         s_lo_r   <= s_lo_nxt;
         s_st_r   <= s_st_nxt;
         hw_r     <= hw_nxt;
         gl_r     <= gl_nxt;
         lo_raw_r <= lo_raw_nxt;
         st_r     <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Local test pulse filter. A low shorter than the pulse limit is bridged only
   // when the previous pulse ended more than the gap ago; otherwise it acts.
   logic [31:0] low_cnt_r, low_cnt_nxt, gap_cnt_r, gap_cnt_nxt;
   logic        lo_r, lo_nxt;

   always_comb begin
      low_cnt_nxt = lo_raw_r ? 32'h0 : low_cnt_r + 32'h1;
      gap_cnt_nxt = gap_cnt_r;
      // High time counts from the end of the last low; a low only freezes it, so the
      // decision below still sees the spacing while the pulse lasts.
      if (lo_raw_r && low_cnt_r != 32'h0)
         gap_cnt_nxt = 32'h1;
      else if (lo_raw_r && gap_cnt_r <= GAP_CYC)
         gap_cnt_nxt = gap_cnt_r + 32'h1;
      lo_nxt = lo_r;
      if (lo_raw_r)
         lo_nxt = 1'b1;
      else if (gap_cnt_r <= GAP_CYC || low_cnt_r >= PULSE_CYC - 1)
         lo_nxt = 1'b0;                                              // see RULE_18
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         low_cnt_r <= 32'h0;
         gap_cnt_r <= 32'h0;
         lo_r      <= 1'b0;
      end else begin
         low_cnt_r <= low_cnt_nxt;
         gap_cnt_r <= gap_cnt_nxt;
         lo_r      <= lo_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers.
   logic [31:0] ctrl_r, ctrl_nxt, tout_r, tout_nxt, rdata_r, rdata_nxt;
   logic [15:0] vthr_r, vthr_nxt, dbil_r, dbil_nxt;
   logic [3:0]  ev_r, ev_nxt, mask_r, mask_nxt, ev_set;
   logic        wait_r, wait_nxt, irq_r, irq_nxt;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
         if (be[i])
            res[8*i +: 8] = d[8*i +: 8];
      return res;
   endfunction

   stop_seq_pkg::stop_state_t st_q, st_d;
   logic [31:0] tcnt_r, tcnt_nxt;
   logic        torque_ok, src_permit, ext_off, stop_req;
   logic        pwr_r, pwr_nxt, ramp_r, ramp_nxt, dyn_r, dyn_nxt, brk_r, brk_nxt;
   logic        sto_r, sto_nxt;
   stop_seq_pkg::fault_t flt;
   logic        acc;

   always_comb begin
      // Every access sees one wait cycle: the request is registered, then answered.
      acc       = (avs_read || avs_write) && wait_r;
      wait_nxt  = !acc;
      ctrl_nxt  = ctrl_r;
      vthr_nxt  = vthr_r;
      tout_nxt  = tout_r;
      dbil_nxt  = dbil_r;
      mask_nxt  = mask_r;
      // An event in the clearing cycle survives the clear.
      ev_nxt    = ev_r | ev_set;
      rdata_nxt = rdata_r;
      if (acc && avs_write) begin
         unique case (avs_address)
            stop_seq_pkg::OFS_CTRL: ctrl_nxt = merge(ctrl_r, avs_writedata, avs_byteenable);
            stop_seq_pkg::OFS_VTHR: vthr_nxt = 16'(merge({16'h0, vthr_r}, avs_writedata,
                                                         avs_byteenable));
            stop_seq_pkg::OFS_TOUT: tout_nxt = merge(tout_r, avs_writedata, avs_byteenable);
            stop_seq_pkg::OFS_DBIL: dbil_nxt = 16'(merge({16'h0, dbil_r}, avs_writedata,
                                                         avs_byteenable));
            stop_seq_pkg::OFS_IRQ:  if (avs_byteenable[0])
                                       ev_nxt = (ev_r & ~avs_writedata[3:0]) | ev_set;
            stop_seq_pkg::OFS_MASK: if (avs_byteenable[0])
                                       mask_nxt = avs_writedata[3:0];
            default: ;
         endcase
      end
      if (acc && avs_read) begin
         unique case (avs_address)
            stop_seq_pkg::OFS_CTRL: rdata_nxt = ctrl_r;
            stop_seq_pkg::OFS_VTHR: rdata_nxt = {16'h0, vthr_r};
            stop_seq_pkg::OFS_TOUT: rdata_nxt = tout_r;
            stop_seq_pkg::OFS_DBIL: rdata_nxt = {16'h0, dbil_r};
            stop_seq_pkg::OFS_STAT: rdata_nxt = {24'h0, brk_r, dyn_r, ramp_r, pwr_r,
                                                 sto_r, lo_r, gl_r, hw_r};
            stop_seq_pkg::OFS_IRQ:  rdata_nxt = {28'h0, ev_r};
            stop_seq_pkg::OFS_MASK: rdata_nxt = {28'h0, mask_r};
            default:                rdata_nxt = 32'h0;
         endcase
      end
      // The interrupt follows the next state so that it rises with its event.
      irq_nxt = |(ev_nxt & mask_nxt);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Stop sequencer.
   always_comb begin
      flt = stop_seq_pkg::fault_t'(fault_class);
      // The local variant takes its permit from its own pin only.
      src_permit = ctrl_r[stop_seq_pkg::BIT_LOCAL] ? lo_r : gl_r;        // see RULE_11
      torque_ok  = src_permit && hw_r;                                  // see RULE_17
      // Torque-off and hardware loss act on the sync output, well inside 10 ms.
      ext_off    = !torque_ok || flt == FLT_IMM;             // see RULE_01 RULE_07 RULE_13 RULE_14
      // Any stop source alone holds the drive out of running.
      stop_req   = st_r || !ctrl_r[stop_seq_pkg::BIT_RUN] || flt == FLT_CTRL;
      st_d       = st_q;
      // The stop timer runs in every stop state and is held clear while off or running.
      tcnt_nxt   = tcnt_r + 32'h1;                                        // see RULE_19
      ev_set     = 4'h0;
      // Any stop in progress ends in the brake at low speed or on timeout.
      if (st_q != ST_BRAKED && st_q != ST_OFF && st_q != ST_RUN &&
          (velocity_abs < vthr_r || tcnt_r >= tout_r)) begin
         st_d = ST_BRAKED;                                                 // see RULE_03
         ev_set[stop_seq_pkg::EV_BRAKE] = 1'b1;
      end
      unique case (st_q)
         ST_OFF: begin
            tcnt_nxt = 32'h0;                                              // see RULE_19
            if (torque_ok && ctrl_r[stop_seq_pkg::BIT_RUN] && !st_r && flt == FLT_NONE)
               st_d = ST_RUN;
         end
         ST_RUN: begin
            tcnt_nxt = 32'h0;
            if (ext_off) begin
               st_d = ST_COAST;
               ev_set[stop_seq_pkg::EV_TORQUE] = !torque_ok;
            end else if (flt == FLT_DYN) begin
               st_d = ST_DYN;                                              // see RULE_08
            end else if (stop_req) begin
               st_d = ST_RAMP;                                 // see RULE_02 RULE_06 RULE_09
            end
            ev_set[stop_seq_pkg::EV_STOP]  = ext_off || flt != FLT_NONE || stop_req;
            ev_set[stop_seq_pkg::EV_FAULT] = flt != FLT_NONE;
         end
         ST_RAMP:  if (ext_off) st_d = ST_COAST;
         ST_DYN:   if (ext_off) st_d = ST_COAST;
         ST_COAST: ;
         ST_BRAKED: begin
            if (!ctrl_r[stop_seq_pkg::BIT_RUN] && flt == FLT_NONE && !st_r)
               st_d = ST_OFF;
         end
      endcase
      // Brake-immediate skips the wait after hardware loss or a fault, in any stop
      // still in progress as well as from running, for axes that carry a load.
      if (ctrl_r[stop_seq_pkg::BIT_BIMM] && (!hw_r || flt != FLT_NONE) &&
          st_q != ST_OFF && st_q != ST_BRAKED)
         st_d = ST_BRAKED;                                                 // see RULE_04
      pwr_nxt  = (st_d == ST_RUN || st_d == ST_RAMP) && torque_ok;
      ramp_nxt = st_d == ST_RAMP;
      // Dynamic braking needs the power stage, shorted on q with d held at zero.
      dyn_nxt  = st_d == ST_DYN && torque_ok;                             // see RULE_16
      // The brake waits out a coast as well; only the stop end or rest applies it.
      brk_nxt  = st_d == ST_OFF || st_d == ST_BRAKED;                    // see RULE_03
      // Purely informational: high while torque is off, local part included.
      sto_nxt  = !gl_r || (ctrl_r[stop_seq_pkg::BIT_LOCAL] && !lo_r);     // see RULE_10 RULE_12
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         st_q   <= ST_OFF;
         tcnt_r <= 32'h0;
         pwr_r  <= 1'b0;
         ramp_r <= 1'b0;
         dyn_r  <= 1'b0;
         brk_r  <= 1'b1;
         sto_r  <= 1'b1;
         ctrl_r <= stop_seq_pkg::CTRL_RST;
         vthr_r <= stop_seq_pkg::VTHR_RST;
         tout_r <= stop_seq_pkg::TOUT_RST;
         dbil_r <= stop_seq_pkg::DBIL_RST;
         mask_r <= 4'h0;
         ev_r   <= 4'h0;
         rdata_r <= 32'h0;
         wait_r <= 1'b1;
         irq_r  <= 1'b0;
      end else begin
         st_q   <= st_d;
         tcnt_r <= tcnt_nxt;
         pwr_r  <= pwr_nxt;
         ramp_r <= ramp_nxt;
         dyn_r  <= dyn_nxt;
         brk_r  <= brk_nxt;
         sto_r  <= sto_nxt;
         ctrl_r <= ctrl_nxt;
         vthr_r <= vthr_nxt;
         tout_r <= tout_nxt;
         dbil_r <= dbil_nxt;
         mask_r <= mask_nxt;
         ev_r   <= ev_nxt;
         rdata_r <= rdata_nxt;
         wait_r <= wait_nxt;
         irq_r  <= irq_nxt;
      end
   end

   // Every output is a register; no path from a pin reaches an output directly.
   assign avs_readdata            = rdata_r;
   assign avs_waitrequest         = wait_r;
   assign power_stage_on          = pwr_r;
   assign ramp_down               = ramp_r;
   assign dyn_brake               = dyn_r;
   assign dyn_brake_ilimit        = dbil_r;
   assign brake_apply             = brk_r;
   assign torque_off_state_output = sto_r;
   assign irq                     = irq_r;
endmodule

// file: bench/stop_seq_monitor.sv
// Port checker for the stop sequencer.
`timescale 1ns/100ps
module stop_seq_monitor (
   input wire logic        clk_sys,
   input wire logic        rst_b,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic        avs_waitrequest,
   input wire logic        string_hardware_permit,
   input wire logic        power_stage_on,
   input wire logic        ramp_down,
   input wire logic        dyn_brake,
   input wire logic [15:0] dyn_brake_ilimit,
   input wire logic        brake_apply
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////////
   bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered after one wait cycle");
   wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   idle_wait_a: assert property (!avs_read && !avs_write |=> avs_waitrequest)
      else $error("waitrequest low without a request");
   hw_cut_a: assert property (
      !string_hardware_permit [*8] |-> !power_stage_on && !ramp_down)
      else $error("power stage still on after hardware permit removal");
   power_rise_a: assert property ($rose(power_stage_on) |->
      string_hardware_permit && $past(string_hardware_permit, 4))
      else $error("power stage released without hardware permit");
   brake_order_a: assert property ($rose(brake_apply) |-> !power_stage_on)
      else $error("brake applied while power stage on");
   ramp_power_a: assert property (
      ramp_down |-> power_stage_on && !brake_apply && !dyn_brake)
      else $error("ramp without power stage or with brake");
   ilimit_hold_a: assert property (
      !avs_write && !$past(avs_write) && !$past(avs_write, 2) |-> $stable(dyn_brake_ilimit))
      else $error("braking current limit changed without a write");
   cover property ($rose(ramp_down));
   cover property ($rose(dyn_brake));
   cover property ($fell(power_stage_on) ##[1:80] $rose(brake_apply));
endmodule
bind stop_sequencer stop_seq_monitor mon_u (.clk_sys, .rst_b, .avs_read, .avs_write,
   .avs_waitrequest, .string_hardware_permit, .power_stage_on, .ramp_down, .dyn_brake,
   .dyn_brake_ilimit, .brake_apply);

// file: bench/permit_host.sv
// Host and safety controller model driving the permit and stop pins.
`timescale 1ns/100ps
module permit_host #(
   parameter int unsigned PULSE_LEN = 2
) (
   input  wire logic       clk_sys,
   input  wire logic [3:0] want,
   input  wire logic       pulse_go,
   output logic            hw_pin,
   output logic            sto_pin,
   output logic            local_pin,
   output logic            stop_pin
);
   int unsigned cnt_r = 0;
   // The host never feeds the torque-off state back into its permits.
   initial {hw_pin, sto_pin, local_pin, stop_pin} = 4'hE;
   always @(posedge clk_sys) begin
      {hw_pin, sto_pin, stop_pin} <= {want[0], want[1], want[3]};
      // A short test pulse drops the local permit, as a checking safety output does.
      cnt_r <= pulse_go ? PULSE_LEN : (cnt_r != 0 ? cnt_r - 1 : 0);
      local_pin <= want[2] && !(pulse_go || cnt_r > 1);
   end
endmodule

// file: bench/tb_stop_sequencer.sv
// Self-checking bench for the stop sequencer.
`timescale 1ns/100ps
module tb_stop_sequencer;
   localparam int PW = 0, RMP = 1, DYN = 2, BRK = 3, SAFE_TORQUE_OFF = 4, IRQ = 5;
   logic        clk_sys = 1'b0;
   logic        rst_b = 1'b0;
   logic [4:0]  avs_address = 5'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [31:0] avs_readdata, rd_v;
   logic        avs_waitrequest, pulse_go = 1'b0;
   logic        string_hardware_permit, torque_off_permit_input, local_torque_off_input;
   logic        stop_input, power_stage_on, ramp_down, dyn_brake, brake_apply;
   logic        torque_off_state_output, irq;
   logic [3:0]  want = 4'h7;
   logic [1:0]  fault_class = 2'h0;
   logic [15:0] velocity_abs = 16'h0100;
   logic [15:0] dyn_brake_ilimit;
   int          n_errors = 0, samples_checked = 0, cycles = 0;
   stop_sequencer #(.PULSE_CYC(4), .GAP_CYC(40)) dut_u (.clk_sys, .rst_b, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .string_hardware_permit, .torque_off_permit_input, .local_torque_off_input, .stop_input,
      .fault_class, .velocity_abs, .power_stage_on, .ramp_down, .dyn_brake, .dyn_brake_ilimit,
      .brake_apply, .torque_off_state_output, .irq);
   permit_host host_u (.clk_sys, .want, .pulse_go, .hw_pin(string_hardware_permit),
      .sto_pin(torque_off_permit_input), .local_pin(local_torque_off_input),
      .stop_pin(stop_input));
   initial forever #2 clk_sys = ~clk_sys;
   ////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      // The tests need well under 1000 cycles; the ceiling leaves ample margin.
      if (cycles == 10000) begin
         n_errors++;
         report_and_stop();
      end
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk_sys);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      rd_v = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (k >= 50) check("bus answer", 32'h0, 32'h1);
   endtask
   task automatic rdchk(input logic [4:0] a, input logic [31:0] e, input string s);
      bus(1'b0, a, 32'h0);
      check(s, e, rd_v);
   endtask
   function automatic logic pick(input int k);
      case (k)
         PW: return power_stage_on;
         RMP: return ramp_down;
         DYN: return dyn_brake;
         BRK: return brake_apply;
         SAFE_TORQUE_OFF: return torque_off_state_output;
         default: return irq;
      endcase
   endfunction
   task automatic bit_is(input string s, input int k, input logic v, input int lim);
      int n;
      n = 0;
      while (pick(k) !== v && n < lim) begin
         @(posedge clk_sys);
         n++;
      end
      check(s, {31'h0, v}, {31'h0, pick(k)});
   endtask
   task automatic pins(input logic [3:0] w, input logic [15:0] v);
      @(posedge clk_sys);
      want <= w;
      velocity_abs <= v;
   endtask
   task automatic enable(input logic [31:0] c);
      bus(1'b1, stop_seq_pkg::OFS_CTRL, c & 32'hFFFF_FFFE);
      // A stop pin just released needs its synchroniser delay before the run bit returns.
      repeat (8) @(posedge clk_sys);
      bus(1'b1, stop_seq_pkg::OFS_CTRL, c | 32'h1);
      bit_is("power on", PW, 1'b1, 20);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      rdchk(stop_seq_pkg::OFS_VTHR, {16'h0, stop_seq_pkg::VTHR_RST}, "vthr");
      rdchk(stop_seq_pkg::OFS_TOUT, stop_seq_pkg::TOUT_RST, "tout");
      rdchk(stop_seq_pkg::OFS_DBIL, {16'h0, stop_seq_pkg::DBIL_RST}, "dbil");
      rdchk(5'h1C, 32'h0, "unmapped");
      bus(1'b1, stop_seq_pkg::OFS_TOUT, 32'h0000_003C);
      bus(1'b1, stop_seq_pkg::OFS_DBIL, 32'h0000_0ABC);
      bit_is("brake at rest", BRK, 1'b1, 0);
      check("ilimit", 32'h0ABC, {16'h0, dyn_brake_ilimit});
      $display("test registers done");
      enable(32'h20);
      bus(1'b1, stop_seq_pkg::OFS_CTRL, 32'h20);
      bit_is("sw ramp", RMP, 1'b1, 12);
      pins(4'h7, 16'h0004);
      bit_is("sw brake", BRK, 1'b1, 14);
      bit_is("sw off", PW, 1'b0, 0);
      pins(4'h7, 16'h0100);
      enable(32'h20);
      pins(4'hF, 16'h0100);
      bit_is("stop ramp", RMP, 1'b1, 14);
      repeat (36) @(posedge clk_sys);
      bit_is("stop early", BRK, 1'b0, 0);
      bit_is("stop timeout", BRK, 1'b1, 40);
      bit_is("stop off", PW, 1'b0, 0);
      pins(4'h7, 16'h0100);
      $display("test controlled stops done");
      for (int b = 0; b < 2; b++) begin
         enable(b ? 32'h22 : 32'h20);
         pins(4'h6, 16'h0100);
         bit_is("hw off", PW, 1'b0, 14);
         bit_is("hw no ramp", RMP, 1'b0, 0);
         bit_is("hw brake", BRK, b[0], 3);
         pins(4'h6, 16'h0004);
         bit_is("hw slow brake", BRK, 1'b1, 14);
         pins(4'h7, 16'h0100);
      end
      $display("test hardware permit done");
      for (int f = 1; f < 4; f++) begin
         enable(32'h20);
         fault_class <= f[1:0];
         bit_is("fault react", f == 1 ? PW : f == 2 ? DYN : RMP, f != 1, 8);
         bit_is("fault ramp", RMP, f == 3, 0);
         bit_is("fault dyn", DYN, f == 2, 0);
         repeat (30) @(posedge clk_sys);
         bit_is("fault early", BRK, 1'b0, 0);
         bit_is("fault brake", BRK, 1'b1, 40);
         fault_class <= 2'h0;
      end
      $display("test faults done");
      enable(32'h20);
      pins(4'h5, 16'h0100);
      bit_is("sto cut", PW, 1'b0, 14);
      bit_is("sto state", SAFE_TORQUE_OFF, 1'b1, 2);
      pins(4'h7, 16'h0004);
      bit_is("sto clear", SAFE_TORQUE_OFF, 1'b0, 14);
      enable(32'h24);
      pins(4'h5, 16'h0100);
      repeat (50) @(posedge clk_sys);
      bit_is("local ignores string", PW, 1'b1, 0);
      pulse_go <= 1'b1;
      @(posedge clk_sys);
      pulse_go <= 1'b0;
      repeat (12) @(posedge clk_sys);
      bit_is("test pulse", PW, 1'b1, 0);
      pins(4'h3, 16'h0100);
      bit_is("local cut", PW, 1'b0, 14);
      bit_is("local state", SAFE_TORQUE_OFF, 1'b1, 2);
      pins(4'h7, 16'h0004);
      $display("test torque off done");
      bit_is("irq masked", IRQ, 1'b0, 0);
      rdchk(stop_seq_pkg::OFS_IRQ, 32'h0000_000F, "irq status");
      bus(1'b1, stop_seq_pkg::OFS_MASK, 32'h0000_000F);
      bit_is("irq raised", IRQ, 1'b1, 4);
      bus(1'b1, stop_seq_pkg::OFS_IRQ, 32'h0000_000F);
      bit_is("irq cleared", IRQ, 1'b0, 4);
      rdchk(stop_seq_pkg::OFS_IRQ, 32'h0, "irq after clear");
      $display("test interrupts done");
      report_and_stop();
   end
endmodule
